//--- hw/dsu_line_config_decoder.sv
// Network and terminal side configuration store and decoder
// Assumes classic Wishbone master, line rate detector pins from another domain
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`include "dsu_line_config_regs.svh"
module dsu_line_config_decoder #(
  parameter int unsigned SHOW_CYCLES = `SHOW_MS * `CLK_KHZ
) (
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_NRST,
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [7:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic      [31:0] O_WB_DAT,
  output logic             O_WB_ACK,
  input  wire logic [3:0]  I_LINE_RATE,
  input  wire logic        I_LINE_LOCK,
  output logic      [3:0]  O_LOOP_RATE,
  output logic      [3:0]  O_DTE_RATE,
  output logic             O_DTE_57K6,
  output logic             O_SEC_OFFER,
  output logic             O_DIAL_MENU,
  output logic             O_MASTER_TIMING,
  output logic             O_EXT_REF,
  output logic             O_SCRAMBLE,
  output logic             O_INVERT,
  output logic             O_LOOP_CODE_SUPPRESS,
  output logic             O_ACCEPT_SHOW,
  output logic             O_FOLLOW_SHOW
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic below_56k(input logic [3:0] rate);
    below_56k = ((rate > `LOOP_AUTO) && (rate < `LOOP_56K)) ||
                ((rate >= `LOOP_SEC_LO) && (rate < `LOOP_56K_SEC));
  endfunction

  function automatic logic loop_code_ok(input logic [3:0] rate);
    loop_code_ok = (rate <= `LOOP_64K) ||
                   ((rate >= `LOOP_SEC_LO) && (rate <= `LOOP_56K_SEC));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta;
  logic rst_n;

  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line rate detector inputs, three stages

  logic [4:0] line_s1;
  logic [4:0] line_s2;
  logic [4:0] line_s3;
  logic [4:0] line_stable;

  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      line_s1     <= 5'h00;
      line_s2     <= 5'h00;
      line_s3     <= 5'h00;
      line_stable <= 5'h00;
    end else begin
      line_s1 <= {I_LINE_LOCK, I_LINE_RATE};
      line_s2 <= line_s1;
      line_s3 <= line_s2;
      if (line_s2 == line_s3) begin
        line_stable <= line_s3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stored settings

  logic [3:0] loop_rate;
  logic [6:0] net_addr;
  logic       remote_en;
  logic [1:0] net_type;
  logic       clk_src;
  logic [3:0] dte_code;
  logic [1:0] scr_code;
  logic [7:0] stage_val;
  logic [3:0] stage_fld;
  logic       stage_remote;
  logic [7:0] term_char;
  logic [5:0] line_len;
  logic       ext_clk_opt;
  logic       async_fmt;
  dsu_line_config_pkg::result_e last_result;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic        bus_req;
  logic        wr_low;
  logic        wr_stage;
  logic        wr_char;
  logic        wr_term;
  logic        wr_ctrl;

  assign bus_req  = I_WB_CYC & I_WB_STB;
  assign wr_low   = bus_req & I_WB_WE & O_WB_ACK & I_WB_SEL[0];
  assign wr_stage = wr_low & (I_WB_ADR == `ADR_STAGE);
  assign wr_char  = wr_low & (I_WB_ADR == `ADR_CHAR);
  assign wr_term  = wr_low & (I_WB_ADR == `ADR_TERM);
  assign wr_ctrl  = wr_low & (I_WB_ADR == `ADR_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // Line assembly and command decode

  logic       is_term;
  logic       too_long;
  logic       exec;
  logic [3:0] eff_loop;
  logic       field_ok;
  logic       follow_refuse;
  logic       remote_block;
  dsu_line_config_pkg::result_e next_result;

  assign is_term  = wr_char & (I_WB_DAT[7:0] == term_char);
  assign too_long = wr_char & ~is_term & (line_len == `LINE_MAX);
  assign exec     = is_term;

  assign field_ok =
    (stage_fld == `FLD_LOOP)   ? loop_code_ok(stage_val[3:0]) & (stage_val[7:4] == 4'h0) :
    (stage_fld == `FLD_ADDR)   ? (stage_val <= {1'b0, `ADDR_MAX}) :
    (stage_fld == `FLD_REMOTE) ? (stage_val == `REM_OFF) | (stage_val == `REM_ON) :
    (stage_fld == `FLD_NET)    ? (stage_val <= {6'h00, `NET_MAX}) :
    (stage_fld == `FLD_CLK)    ? (stage_val <= {7'h00, `CLK_LINE}) :
    (stage_fld == `FLD_DTE)    ? (stage_val >= {4'h0, `DTE_LO}) &
                                 (stage_val <= {4'h0, `DTE_FOLLOW}) :
    (stage_fld == `FLD_SCR)    ? (stage_val <= {6'h00, `SCR_ALT}) :
    1'b0;

  assign follow_refuse = (stage_fld == `FLD_DTE) & below_56k(eff_loop);
  assign remote_block  = stage_remote & ~remote_en;

  assign next_result = remote_block  ? dsu_line_config_pkg::RES_REJECTED :
                       !field_ok     ? dsu_line_config_pkg::RES_INVALID  :
                       follow_refuse ? dsu_line_config_pkg::RES_REFUSED  :
                                       dsu_line_config_pkg::RES_OK;

  logic do_set;
  assign do_set = exec & (next_result == dsu_line_config_pkg::RES_OK);

  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      stage_val    <= 8'h00;
      stage_fld    <= 4'h0;
      stage_remote <= 1'b0;
      term_char    <= `TERM_RESET;
      line_len     <= 6'h00;
      ext_clk_opt  <= 1'b0;
      async_fmt    <= 1'b0;
      last_result  <= dsu_line_config_pkg::RES_NONE;
    end else begin
      if (wr_stage) begin
        stage_val    <= I_WB_DAT[7:0];
        stage_fld    <= I_WB_DAT[11:8];
        stage_remote <= I_WB_DAT[16];
      end
      if (wr_term) begin
        term_char <= I_WB_DAT[7:0];
      end
      if (wr_ctrl) begin
        ext_clk_opt <= I_WB_DAT[0];
        async_fmt   <= I_WB_DAT[1];
      end
      if (is_term || too_long) begin
        line_len <= 6'h00;
      end else if (wr_char) begin
        line_len <= line_len + 6'h01;
      end
      if (exec) begin
        last_result <= next_result;
      end else if (too_long) begin
        last_result <= dsu_line_config_pkg::RES_OVERFLOW;
      end
    end
  end

  // Each setting has its own storage; one command touches one field
  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      loop_rate <= `LOOP_AUTO;
      net_addr  <= 7'h00;
      remote_en <= 1'b1;
      net_type  <= 2'h0;
      clk_src   <= `CLK_LINE;
      dte_code  <= `DTE_FOLLOW;
      scr_code  <= `SCR_OFF;
    end else if (do_set) begin
      case (stage_fld)
        `FLD_LOOP:   loop_rate <= stage_val[3:0];
        `FLD_ADDR:   net_addr  <= stage_val[6:0];
        `FLD_REMOTE: remote_en <= (stage_val == `REM_ON);
        `FLD_NET:    net_type  <= stage_val[1:0];
        `FLD_CLK:    clk_src   <= stage_val[0];
        `FLD_DTE:    dte_code  <= stage_val[3:0];
        `FLD_SCR:    scr_code  <= stage_val[1:0];
        default:     loop_rate <= loop_rate;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective operating state

  logic [3:0] detect_rate;
  logic       detect_ok;
  logic [3:0] next_eff_loop;
  logic [3:0] next_dte;
  logic       scr_applies;

  assign detect_ok   = line_stable[4] & loop_code_ok(line_stable[3:0]) &
                       (line_stable[3:0] != `LOOP_AUTO);
  assign detect_rate = (line_stable[3:0] == `LOOP_64K) ? `LOOP_56K_SEC :
                       line_stable[3:0];
  assign next_eff_loop = (loop_rate != `LOOP_AUTO) ? loop_rate :
                         detect_ok ? detect_rate : `LOOP_AUTO;
  assign next_dte = below_56k(eff_loop) ? `DTE_FOLLOW : dte_code;
  assign scr_applies = (eff_loop == `LOOP_56K_SEC) | (eff_loop == `LOOP_64K);

  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      eff_loop             <= `LOOP_AUTO;
      O_LOOP_RATE          <= `LOOP_AUTO;
      O_DTE_RATE           <= `DTE_FOLLOW;
      O_DTE_57K6           <= 1'b0;
      O_SEC_OFFER          <= 1'b0;
      O_DIAL_MENU          <= 1'b0;
      O_MASTER_TIMING      <= 1'b0;
      O_EXT_REF            <= 1'b0;
      O_SCRAMBLE           <= 1'b0;
      O_INVERT             <= 1'b0;
      O_LOOP_CODE_SUPPRESS <= 1'b0;
    end else begin
      eff_loop             <= next_eff_loop;
      O_LOOP_RATE          <= eff_loop;
      O_DTE_RATE           <= next_dte;
      O_DTE_57K6           <= (next_dte == `DTE_56K) & async_fmt;
      O_SEC_OFFER          <= (loop_rate != `LOOP_AUTO) & (loop_rate != `LOOP_64K);
      O_DIAL_MENU          <= (net_type != `NET_LEASED);
      O_MASTER_TIMING      <= (clk_src == `CLK_MASTER);
      O_EXT_REF            <= (clk_src == `CLK_MASTER) & ext_clk_opt;
      O_SCRAMBLE           <= scr_applies & (scr_code == `SCR_ON);
      O_INVERT             <= (eff_loop == `LOOP_56K_SEC) & (scr_code == `SCR_ALT);
      O_LOOP_CODE_SUPPRESS <= (eff_loop == `LOOP_64K) & (scr_code == `SCR_ALT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Brief indications

  dsu_line_config_pkg::show_e show_state;
  dsu_line_config_pkg::show_e next_show;
  logic [31:0] show_cnt;
  logic        show_done;

  assign show_done = (show_cnt == (SHOW_CYCLES - 32'h1));

  always_comb begin
    next_show = show_state;
    if (exec && next_result == dsu_line_config_pkg::RES_OK) begin
      next_show = dsu_line_config_pkg::SHOW_ACCEPT;
    end else if (exec && next_result == dsu_line_config_pkg::RES_REFUSED) begin
      next_show = dsu_line_config_pkg::SHOW_FOLLOW;
    end else begin
      case (show_state)
        dsu_line_config_pkg::SHOW_IDLE:   next_show = show_state;
        dsu_line_config_pkg::SHOW_ACCEPT,
        dsu_line_config_pkg::SHOW_FOLLOW: begin
          if (show_done) begin
            next_show = dsu_line_config_pkg::SHOW_IDLE;
          end
        end
        default: next_show = dsu_line_config_pkg::SHOW_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      show_state    <= dsu_line_config_pkg::SHOW_IDLE;
      show_cnt      <= 32'h0;
      O_ACCEPT_SHOW <= 1'b0;
      O_FOLLOW_SHOW <= 1'b0;
    end else begin
      show_state <= next_show;
      if (exec || next_show == dsu_line_config_pkg::SHOW_IDLE) begin
        show_cnt <= 32'h0;
      end else begin
        show_cnt <= show_cnt + 32'h1;
      end
      O_ACCEPT_SHOW <= (next_show == dsu_line_config_pkg::SHOW_ACCEPT);
      O_FOLLOW_SHOW <= (next_show == dsu_line_config_pkg::SHOW_FOLLOW);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and acknowledge

  logic [31:0] rd_data;

  assign rd_data =
    (I_WB_ADR == `ADR_STAGE)  ? {15'h0, stage_remote, 4'h0, stage_fld, stage_val} :
    (I_WB_ADR == `ADR_CHAR)   ? {26'h0, line_len} :
    (I_WB_ADR == `ADR_TERM)   ? {24'h0, term_char} :
    (I_WB_ADR == `ADR_STATUS) ? {16'h0, O_DTE_RATE, eff_loop, 2'h0, detect_ok,
                                 O_FOLLOW_SHOW, O_ACCEPT_SHOW, last_result} :
    (I_WB_ADR == `ADR_CONFIG) ? {10'h0, scr_code, dte_code, 1'b0, clk_src,
                                 net_type, remote_en, net_addr, loop_rate} :
    (I_WB_ADR == `ADR_CTRL)   ? {30'h0, async_fmt, ext_clk_opt} :
    32'h0;

  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0;
    end else begin
      O_WB_ACK <= bus_req & ~O_WB_ACK;
      O_WB_DAT <= (bus_req & ~O_WB_ACK & ~I_WB_WE) ? rd_data : 32'h0;
    end
  end

endmodule // dsu_line_config_decoder

//--- hw/dsu_line_config_pkg.sv
// Types shared by the line config decoder
// Assumes nothing beyond the constants header
package dsu_line_config_pkg;
  typedef enum logic [2:0] {
    RES_NONE     = 3'b000,
    RES_OK       = 3'b001,
    RES_INVALID  = 3'b010,
    RES_REFUSED  = 3'b011,
    RES_REJECTED = 3'b100,
    RES_OVERFLOW = 3'b101
  } result_e;
  typedef enum logic [1:0] {
    SHOW_IDLE    = 2'b00,
    SHOW_ACCEPT  = 2'b01,
    SHOW_FOLLOW  = 2'b10
  } show_e;
endpackage

//--- hw/dsu_line_config_regs.svh
// Register offsets, codes, reset values and timing for the line config decoder
// Assumes a 32-bit classic Wishbone slave clocked at 25 MHz
// Function
// - Automatic loop rate locks to line rate
// - Auto sees 64k or 56k-sec as 56k-sec
// - Loop codes 0 auto, 1-7, 9-14
// - Secondary channel only on fixed non-64k rates
// - Loop rate stored apart from terminal rate
// - Two-digit decimal address, default zero
// - Remote config flag, 4 off, 5 on
// - Network type 0 leased, 1-2 switched
// - Switched types enable dialing and dial menu
// - Clock source 1 line, 0 master
// - Master uses oscillator unless external enabled
// - Slow loop forces terminal rate, refuse changes
// - Terminal codes 3-9, 9 follows line
// - Code 8 is 56k sync, 57.6k async
// - Scrambler code 0 off, 1 on
// - Show acceptance briefly after good setting
// - Execute on terminator, lines at most 40
`ifndef DSU_LINE_CONFIG_REGS_SVH
`define DSU_LINE_CONFIG_REGS_SVH

`define ADR_STAGE      8'h00
`define ADR_CHAR       8'h04
`define ADR_TERM       8'h08
`define ADR_STATUS     8'h0C
`define ADR_CONFIG     8'h10
`define ADR_CTRL       8'h14

`define FLD_LOOP       4'h0
`define FLD_ADDR       4'h1
`define FLD_REMOTE     4'h2
`define FLD_NET        4'h3
`define FLD_CLK        4'h4
`define FLD_DTE        4'h5
`define FLD_SCR        4'h6

`define LOOP_AUTO      4'h0
`define LOOP_56K       4'h6
`define LOOP_64K       4'h7
`define LOOP_SEC_LO    4'h9
`define LOOP_56K_SEC   4'hE
`define DTE_LO         4'h3
`define DTE_FOLLOW     4'h9
`define DTE_56K        4'h8
`define NET_LEASED     2'h0
`define ADDR_MAX       7'h63
`define REM_OFF        8'h04
`define REM_ON         8'h05
`define NET_MAX        2'h2
`define SCR_OFF        2'h0
`define SCR_ON         2'h1
`define SCR_ALT        2'h2
`define CLK_MASTER     1'h0
`define CLK_LINE       1'h1

`define TERM_RESET     8'h0D
`define LINE_MAX       6'h28

`define CLK_KHZ        25000
`define SHOW_MS        1000

`endif

//--- verif/dsu_line_config_decoder_sva.sv
// Port checker for the line config decoder
// Assumes binding to the decoder with a show time of 8 cycles
`timescale 1ns/1ps
module dsu_line_config_decoder_sva #(
  parameter int unsigned SHOW_CYCLES = 8
) (
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_NRST,
  input  wire logic        I_WB_STB,
  input  wire logic [31:0] O_WB_DAT,
  input  wire logic        O_WB_ACK,
  input  wire logic [3:0]  O_LOOP_RATE,
  input  wire logic [3:0]  O_DTE_RATE,
  input  wire logic        O_SEC_OFFER,
  input  wire logic        O_DIAL_MENU,
  input  wire logic        O_MASTER_TIMING,
  input  wire logic        O_EXT_REF,
  input  wire logic        O_SCRAMBLE,
  input  wire logic        O_INVERT,
  input  wire logic        O_LOOP_CODE_SUPPRESS,
  input  wire logic        O_ACCEPT_SHOW,
  input  wire logic        O_FOLLOW_SHOW
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_NRST);
  ////////////////////////////////////////////////////////////////////////
  logic [3:0] ack_hist;
  wire        recent_ack = O_WB_ACK | (|ack_hist);
  wire        slow       = O_LOOP_RATE inside {[4'h1:4'h5], [4'h9:4'hD]};
  wire        fast       = O_LOOP_RATE inside {4'h7, 4'hE};
  wire        no_sec     = O_LOOP_RATE inside {4'h0, 4'h7};
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ack_hist <= 4'h0;
    end else begin
      ack_hist <= {ack_hist[2:0], O_WB_ACK};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_show(x);
    x [*8] ##[1:2] !x;
  endsequence
  sequence s_slow;
    slow [*3];
  endsequence
  AST_ACK_PULSE: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property ($rose(O_WB_ACK) |-> $past(I_WB_STB))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0)
    else $error("read data outside ack");
  AST_ACCEPT_TIME: assert property (
    $rose(O_ACCEPT_SHOW) |-> s_show(O_ACCEPT_SHOW)) else $error("accept show length");
  AST_FOLLOW_TIME: assert property (
    $rose(O_FOLLOW_SHOW) |-> s_show(O_FOLLOW_SHOW)) else $error("follow show length");
  AST_SHOW_CAUSE: assert property (
    $rose(O_ACCEPT_SHOW) || $rose(O_FOLLOW_SHOW) |-> recent_ack) else $error("show uncaused");
  AST_SLOW_DTE: assert property (
    s_slow |-> O_DTE_RATE == 4'h9) else $error("terminal rate not following slow loop");
  AST_SEC_OFFER: assert property (
    O_SEC_OFFER [*3] |-> !no_sec) else $error("secondary offered on auto or 64k");
  AST_SCR_LOOP: assert property (
    (!fast) [*3] |-> !O_SCRAMBLE) else $error("scrambler on wrong loop");
  AST_INV_LOOP: assert property (
    (O_LOOP_RATE != 4'hE) [*3] |-> !O_INVERT) else $error("invert on wrong loop");
  AST_SUP_LOOP: assert property (
    (O_LOOP_RATE != 4'h7) [*3] |-> !O_LOOP_CODE_SUPPRESS) else $error("suppress on wrong loop");
  AST_CFG_QUIET: assert property (
    $changed({O_DIAL_MENU, O_MASTER_TIMING}) |-> recent_ack) else $error("config moved alone");
  AST_EXT_MASTER: assert property (
    O_EXT_REF |-> O_MASTER_TIMING || $past(O_MASTER_TIMING)) else $error("ext ref not master");
endmodule // dsu_line_config_decoder_sva

//--- verif/dsu_line_config_decoder_tb_top.sv
// Self-checking bench with a reference model of the settings
// Assumes show time shortened to 8 cycles, 25 MHz clock
`timescale 1ns/1ps
`include "dsu_line_config_regs.svh"
module dsu_line_config_decoder_tb_top;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic [3:0]  set_rate = 4'h0;
  logic        set_lock = 1'b0;
  logic [3:0]  line_rate;
  logic        line_lock;
  logic [3:0]  loop_o;
  logic [3:0]  dte_o;
  wire logic [7:0] flags;
  logic        acc_o;
  logic        fol_o;
  logic [31:0] q;
  int          n_fail = 0;
  int          checked = 0;
  int m_loop = 0, m_addr = 0, m_rem = 1, m_net = 0, m_clk = 1, m_dte = 9, m_scr = 0;
  int m_ctrl = 0, m_res = 0, term = 13;
  int m_ctrl_loops[$] = '{14, 7};
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  dsu_line_config_decoder #(.SHOW_CYCLES(8)) i_dsu_line_config_decoder (
    .I_SYS_CLK(clk), .I_NRST(nrst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_LINE_RATE(line_rate), .I_LINE_LOCK(line_lock), .O_LOOP_RATE(loop_o),
    .O_DTE_RATE(dte_o), .O_DTE_57K6(flags[7]), .O_SEC_OFFER(flags[6]),
    .O_DIAL_MENU(flags[5]), .O_MASTER_TIMING(flags[4]), .O_EXT_REF(flags[3]),
    .O_SCRAMBLE(flags[2]), .O_INVERT(flags[1]), .O_LOOP_CODE_SUPPRESS(flags[0]),
    .O_ACCEPT_SHOW(acc_o), .O_FOLLOW_SHOW(fol_o));
  line_detector_model i_line_detector_model (.i_clk(clk), .i_set_rate(set_rate),
    .i_set_lock(set_lock), .o_rate(line_rate), .o_lock(line_lock));
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    chk("ack wait", 32'(n), 32'h2);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  function automatic int eff_loop();
    if (m_loop != 0) return m_loop;
    if (!set_lock) return 0;
    return (set_rate == 4'h7) ? 14 : int'(set_rate);
  endfunction
  function automatic bit slow(input int l);
    return (l >= 1 && l <= 5) || (l >= 9 && l <= 13);
  endfunction
  task automatic check();
    int l;
    int d;
    l = eff_loop();
    d = slow(l) ? 9 : m_dte;
    wb(1'b0, `ADR_STATUS, 32'h0);
    chk("result", {29'h0, q[2:0]}, 32'(m_res));
    chk("show idle", {30'h0, acc_o, fol_o}, 32'h0);
    wb(1'b0, `ADR_CONFIG, 32'h0);
    chk("config", q, 32'(m_loop | m_addr << 4 | m_rem << 11 | m_net << 12 | m_clk << 14
        | m_dte << 16 | m_scr << 20));
    chk("outputs", {16'h0, loop_o, dte_o, flags}, {16'h0, 4'(l), 4'(d), d == 8 && m_ctrl[1],
        m_loop != 0 && m_loop != 7, m_net != 0, m_clk == 0, m_clk == 0 && m_ctrl[0],
        m_scr == 1 && (l == 7 || l == 14), m_scr == 2 && l == 14,
        m_scr == 2 && l == 7});
  endtask
  task automatic cmd(input int f, input int v, input int far);
    bit ok;
    case (f)
      0: ok = v <= 14 && v != 8;
      1: ok = v <= 99;
      2: ok = v == 4 || v == 5;
      3: ok = v <= 2;
      4: ok = v <= 1;
      5: ok = v >= 3 && v <= 9;
      default: ok = v <= 2;
    endcase
    if (far != 0 && m_rem == 0) m_res = 4;
    else if (!ok) m_res = 2;
    else if (f == 5 && slow(eff_loop())) m_res = 3;
    else begin
      m_res = 1;
      case (f)
        0: m_loop = v;
        1: m_addr = v;
        2: m_rem = v - 4;
        3: m_net = v;
        4: m_clk = v;
        5: m_dte = v;
        default: m_scr = v;
      endcase
    end
    wb(1'b1, `ADR_STAGE, 32'(far << 16 | f << 8 | v));
    wb(1'b1, `ADR_CHAR, 32'(term));
    @(posedge clk);
    chk("show", {30'h0, acc_o, fol_o}, {30'h0, m_res == 1, m_res == 3});
    repeat (12) @(posedge clk);
    check();
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h3e65));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    check();
    wb(1'b1, `ADR_CTRL, 32'h3);
    m_ctrl = 3;
    for (int c = 0; c < 16; c++) cmd(0, c, 0);
    cmd(0, 6, 0);
    for (int c = 0; c < 11; c++) cmd(5, c, 0);
    cmd(0, 3, 0);
    cmd(5, 4, 0);
    foreach (m_ctrl_loops[i]) begin
      cmd(0, m_ctrl_loops[i], 0);
      for (int s = 0; s < 4; s++) cmd(6, s, 0);
    end
    for (int c = 0; c < 4; c++) cmd(3, c, 0);
    for (int c = 0; c < 3; c++) cmd(4, c, 0);
    cmd(2, 4, 0);
    cmd(1, 42, 1);
    cmd(2, 5, 1);
    cmd(2, 5, 0);
    cmd(1, 99, 1);
    cmd(1, 100, 0);
    cmd(0, 0, 0);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      set_lock <= 1'b1;
      set_rate <= (i == 0) ? 4'h7 : 4'h3;
      repeat (10) @(posedge clk);
      check();
    end
    cmd(5, 5, 0);
    wb(1'b1, `ADR_TERM, 32'h21);
    term = 33;
    wb(1'b1, `ADR_STAGE, 32'h137);
    wb(1'b1, `ADR_CHAR, 32'hD);
    check();
    wb(1'b1, `ADR_CHAR, 32'h21);
    m_addr = 55;
    m_res = 1;
    repeat (12) @(posedge clk);
    check();
    for (int i = 0; i < 41; i++) wb(1'b1, `ADR_CHAR, 32'h41);
    m_res = 5;
    check();
    for (int i = 0; i < 40; i++) wb(1'b1, `ADR_CHAR, 32'h41);
    cmd(1, 12, 0);
    repeat (4) begin
      m_ctrl = int'($urandom_range(0, 3));
      wb(1'b1, `ADR_CTRL, 32'(m_ctrl));
      repeat (10) cmd(int'($urandom_range(0, 6)), int'($urandom_range(0, 15)),
                      int'($urandom_range(0, 3) == 0));
    end
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, 32'h0);
    wb(1'b0, `ADR_TERM, 32'h0);
    chk("term", q, 32'h21);
    wrap_up();
  end
endmodule // dsu_line_config_decoder_tb_top

bind dsu_line_config_decoder dsu_line_config_decoder_sva #(.SHOW_CYCLES(SHOW_CYCLES))
  i_dsu_line_config_decoder_sva (.I_SYS_CLK(I_SYS_CLK), .I_NRST(I_NRST),
  .I_WB_STB(I_WB_STB), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
  .O_LOOP_RATE(O_LOOP_RATE), .O_DTE_RATE(O_DTE_RATE), .O_SEC_OFFER(O_SEC_OFFER),
  .O_DIAL_MENU(O_DIAL_MENU), .O_MASTER_TIMING(O_MASTER_TIMING), .O_EXT_REF(O_EXT_REF),
  .O_SCRAMBLE(O_SCRAMBLE), .O_INVERT(O_INVERT),
  .O_LOOP_CODE_SUPPRESS(O_LOOP_CODE_SUPPRESS), .O_ACCEPT_SHOW(O_ACCEPT_SHOW),
  .O_FOLLOW_SHOW(O_FOLLOW_SHOW));

//--- verif/line_detector_model.sv
// Line rate detector stand-in feeding the automatic rate input
// Assumes the bench sets rate and lock on the system clock
`timescale 1ns/1ps
module line_detector_model (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_set_rate,
  input  wire logic       i_set_lock,
  output logic      [3:0] o_rate = 4'hA,
  output logic            o_lock = 1'b0
);
  // Unlocked detector shows a wandering code
  always @(posedge i_clk) begin
    o_lock <= i_set_lock;
    o_rate <= i_set_lock ? i_set_rate : ~o_rate;
  end
endmodule // line_detector_model
